// [hw/ovp_defs.vh]
`ifndef OVP_DEFS_VH
`define OVP_DEFS_VH
`define OVP_CLK_MHZ 125
`define OVP_CYCLE_US 5000
`define OVP_A_CTRL 8'h00
`define OVP_A_USET 8'h04
`define OVP_A_DT 8'h08
`define OVP_A_K 8'h0C
`define OVP_A_EXPO 8'h10
`define OVP_A_REL 8'h14
`define OVP_A_UNPRI 8'h18
`define OVP_A_STAT 8'h20
`define OVP_A_EXPT 8'h24
`define OVP_A_REMT 8'h28
`define OVP_A_RATA 8'h2C
`define OVP_A_RATB 8'h30
`define OVP_A_RATC 8'h34
`define OVP_A_RATM 8'h38
`define OVP_A_PRI 8'h3C
`define OVP_A_EVT 8'h40
`define OVP_A_EVTV 8'h44
`define OVP_CTRL_CRIT 0
`define OVP_CTRL_MSEL 2
`define OVP_CTRL_DTYPE 4
`define OVP_CTRL_RELEN 6
`define OVP_CTRL_FORCE 7
`define OVP_CTRL_SWBLK 8
`define OVP_RST_CTRL 32'h0000_0050
`define OVP_RST_USET 16'h2904
`define OVP_RST_DT 19'h0_0008
`define OVP_RST_K 13'h0005
`define OVP_RST_EXPO 12'h064
`define OVP_RST_REL 19'h0_000C
`define OVP_RST_UNPRI 32'h0003_0D40
`define OVP_DTYPE_DT 2'h1
`define OVP_DTYPE_INVERSE_DELAY_MODE 2'h2
`define OVP_RESET_PCT 7'h61
`define OVP_PCT_FULL 7'h64
`define OVP_PRI_DIV 48'h0000_0000_2710
`define OVP_MAX_TICKS 19'h5_7E40
`define OVP_Q16_ONE 32'h0001_0000
`define OVP_RESP_OKAY 2'h0
`define OVP_RESP_SLVERR 2'h2
`endif

// [hw/ovp_stage.v]
// Function
// - Pick up when a measured voltage rises above the common threshold.
// - Drop pick-up only below 97 percent of the threshold.
// - Criterion 0, 1, 2 needs one, two or three voltages over; default one.
// - Threshold held in 0.01 percent of nominal, default 105 percent.
// - Ratio of each voltage to the one common threshold computed once per program cycle.
// - START set while pick-up is present and blocking is inactive; held through the release delay.
// - Blocking input sampled at the start of each program cycle.
// - Blocked at pick-up: raise BLOCKED, no START and no timing.
// - Block after START: drop START, release timing as if pick-up ended.
// - Blocking issues an event carrying startup voltage and fault type.
// - Software switch drives blocking only in stage forcing test mode.
// - Instant mode trips in the same cycle as START.
// - Fixed delay mode trips after the set delay while pick-up persists.
// - Inverse mode time is dial over ratio to the exponent minus one.
// - Expected operating time reported in 5 ms steps, tracking voltage.
// - Signed remaining time to trip reported in 5 ms steps.
// - Per-phase and overall ratios reported with 0.01 resolution.
// - Pick-up level reported in primary volts, 0.1 V resolution.
// - Timer behaviour configurable for trip and for release.
// - Delay type 1 fixed, 2 inverse, default fixed.
// - Fixed delay zero acts as instant; otherwise 5 ms steps.
// - Magnitude select: 0 phase-phase, 1 phase-earth, 2 channel 3, 3 channel 4.
`timescale 1ns/1ps
`default_nettype none
`include "ovp_defs.vh"
module ovp_stage #(
  parameter integer CYCLE_CLKS = `OVP_CYCLE_US * `OVP_CLK_MHZ // Program cycle in clocks
)(
  input wire clk, // 125 MHz clock
  input wire rst, // Async reset, high
  input wire [7:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [7:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire [15:0] v_pp_a, // Phase-phase AB, 0.01 %Un
  input wire [15:0] v_pp_b, // Phase-phase BC
  input wire [15:0] v_pp_c, // Phase-phase CA
  input wire [15:0] v_pe_a, // Phase-earth A
  input wire [15:0] v_pe_b, // Phase-earth B
  input wire [15:0] v_pe_c, // Phase-earth C
  input wire [15:0] v_ch3, // Third input channel
  input wire [15:0] v_ch4, // Fourth input channel
  input wire blk_in, // Blocking matrix input
  output reg pickup, // Pick-up condition
  output reg start, // START
  output reg trip, // TRIP
  output reg blocked, // BLOCKED
  output reg evt_block, // Blocking event pulse
  output reg [2:0] evt_fault, // Channels over at blocking
  output reg [15:0] evt_volt // Highest voltage at blocking
);
  localparam S_IDLE = 2'h0;
  localparam S_DIV = 2'h1;
  localparam S_EXP = 2'h2;
  localparam S_EVAL = 2'h3;

  reg [31:0] ctrl_ff;
  reg [15:0] uset_ff;
  reg [18:0] dt_ff;
  reg [12:0] k_ff;
  reg [11:0] expo_ff;
  reg [18:0] rel_ff;
  reg [31:0] unpri_ff;
  reg [7:0] aw_addr_ff;
  reg aw_hold_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg w_hold_ff;
  reg blk_s1_ff;
  reg blk_s2_ff;
  reg blk_smp_ff;
  reg [19:0] tick_cnt_ff;
  reg [1:0] st_ff;
  reg [1:0] idx_ff;
  reg [5:0] bit_ff;
  reg [31:0] num_ff;
  reg [31:0] den_ff;
  reg [32:0] rem_ff;
  reg [15:0] vl_ff [0:2];
  reg [31:0] rq_ff [0:2];
  reg [2:0] ovr_ff;
  reg [18:0] inverse_delay_mode_ff;
  reg [31:0] em1_ff;
  reg [18:0] op_ff;
  reg [18:0] relc_ff;
  reg run_ff;
  reg [19:0] remt_ff;
  reg [15:0] blkcnt_ff;

  wire [1:0] crit = ctrl_ff[`OVP_CTRL_CRIT +: 2];
  wire [1:0] msel = ctrl_ff[`OVP_CTRL_MSEL +: 2];
  wire [1:0] dtype = ctrl_ff[`OVP_CTRL_DTYPE +: 2];
  wire rel_en = ctrl_ff[`OVP_CTRL_RELEN];
  wire force_en = ctrl_ff[`OVP_CTRL_FORCE];
  wire sw_blk = ctrl_ff[`OVP_CTRL_SWBLK];

  // Software block only reachable in stage forcing mode
  wire blk_eff = blk_s2_ff | (force_en & sw_blk);

  reg [15:0] vsel0;
  reg [15:0] vsel1;
  reg [15:0] vsel2;
  always @* begin
    case (msel)
      2'h0: begin
        vsel0 = v_pp_a;
        vsel1 = v_pp_b;
        vsel2 = v_pp_c;
      end
      2'h1: begin
        vsel0 = v_pe_a;
        vsel1 = v_pe_b;
        vsel2 = v_pe_c;
      end
      2'h2: begin
        vsel0 = v_ch3;
        vsel1 = 16'h0000;
        vsel2 = 16'h0000;
      end
      default: begin
        vsel0 = v_ch4;
        vsel1 = 16'h0000;
        vsel2 = 16'h0000;
      end
    endcase
  end

  // Per-channel hysteresis comparator and displayed ratio
  wire [2:0] ovr_nxt;
  wire [10:0] ratio [0:2];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ch
      wire [22:0] v_pct = vl_ff[gi] * `OVP_PCT_FULL;
      wire [22:0] rs_pct = uset_ff * `OVP_RESET_PCT;
      // Round to the nearest hundredth; the Q16 quotient truncates
      wire [38:0] rq_pct = rq_ff[gi] * `OVP_PCT_FULL + 39'h00_0000_8000;
      assign ovr_nxt[gi] = ovr_ff[gi] ? (v_pct >= rs_pct) : (vl_ff[gi] > uset_ff);
      assign ratio[gi] = rq_pct[26:16];
    end
  endgenerate

  wire [1:0] n_ovr = {1'b0, ovr_nxt[0]} + {1'b0, ovr_nxt[1]} + {1'b0, ovr_nxt[2]};
  wire [1:0] need = msel[1] ? 2'h1 : ((crit == 2'h0) ? 2'h1 : ((crit == 2'h1) ? 2'h2 : 2'h3));
  wire pick_nxt = (n_ovr >= need) && (ovr_nxt != 3'h0);

  wire [31:0] rq_m01 = (rq_ff[0] > rq_ff[1]) ? rq_ff[0] : rq_ff[1];
  wire [31:0] rq_max = (rq_m01 > rq_ff[2]) ? rq_m01 : rq_ff[2];
  wire [15:0] v_m01 = (vl_ff[0] > vl_ff[1]) ? vl_ff[0] : vl_ff[1];
  wire [15:0] v_max = (v_m01 > vl_ff[2]) ? v_m01 : vl_ff[2];
  wire [38:0] rqm_pct = rq_max * `OVP_PCT_FULL + 39'h00_0000_8000;

  // Series for r^a - 1; good near pick-up, limited to ratio 2
  wire [31:0] dlt_raw = (rq_max > `OVP_Q16_ONE) ? rq_max - `OVP_Q16_ONE : 32'h0000_0000;
  wire [16:0] dlt = (dlt_raw > `OVP_Q16_ONE) ? 17'h1_0000 : dlt_raw[16:0];
  wire [33:0] dlt_sq = dlt * dlt;
  wire [16:0] ln_q = dlt - {1'b0, dlt_sq[32:17]};
  wire [28:0] aln = ln_q * expo_ff;
  wire [28:0] y_full = aln / `OVP_PCT_FULL;
  wire [20:0] y_q = y_full[20:0];
  wire [41:0] y_sq = y_q * y_q;
  wire [31:0] em1 = {11'h000, y_q} + {7'h00, y_sq[41:17]};

  wire [32:0] rem_sh = {rem_ff[31:0], num_ff[31]};
  wire rem_ge = rem_sh >= {1'b0, den_ff};

  wire [18:0] exp_t = (dtype == `OVP_DTYPE_INVERSE_DELAY_MODE) ? inverse_delay_mode_ff : dt_ff;
  wire pick_ok = pick_nxt & ~blk_smp_ff;
  wire [18:0] op_nxt = run_ff ? op_ff + 19'h0_0001 : op_ff;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      blk_s1_ff <= 1'b0;
      blk_s2_ff <= 1'b0;
      tick_cnt_ff <= 20'h0_0000;
    end else begin
      blk_s1_ff <= blk_in;
      blk_s2_ff <= blk_s1_ff;
      if (tick_cnt_ff == CYCLE_CLKS - 1)
        tick_cnt_ff <= 20'h0_0000;
      else
        tick_cnt_ff <= tick_cnt_ff + 20'h0_0001;
    end
  end
  wire tick = (tick_cnt_ff == CYCLE_CLKS - 1);

  integer i;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= S_IDLE;
      idx_ff <= 2'h0;
      bit_ff <= 6'h00;
      num_ff <= 32'h0000_0000;
      den_ff <= 32'h0000_0000;
      rem_ff <= 33'h0_0000_0000;
      blk_smp_ff <= 1'b0;
      em1_ff <= 32'h0000_0000;
      inverse_delay_mode_ff <= 19'h0_0000;
      for (i = 0; i < 3; i = i + 1) begin
        vl_ff[i] <= 16'h0000;
        rq_ff[i] <= 32'h0000_0000;
      end
      ovr_ff <= 3'h0;
      pickup <= 1'b0;
      start <= 1'b0;
      trip <= 1'b0;
      blocked <= 1'b0;
      op_ff <= 19'h0_0000;
      relc_ff <= 19'h0_0000;
      run_ff <= 1'b0;
      remt_ff <= 20'h0_0000;
      evt_block <= 1'b0;
      evt_fault <= 3'h0;
      evt_volt <= 16'h0000;
      blkcnt_ff <= 16'h0000;
    end else begin
      evt_block <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (tick) begin
            blk_smp_ff <= blk_eff;
            vl_ff[0] <= vsel0;
            vl_ff[1] <= vsel1;
            vl_ff[2] <= vsel2;
            num_ff <= {vsel0, 16'h0000};
            den_ff <= {16'h0000, uset_ff};
            rem_ff <= 33'h0_0000_0000;
            bit_ff <= 6'h00;
            idx_ff <= 2'h0;
            st_ff <= S_DIV;
          end
        end
        S_DIV: begin
          rem_ff <= rem_ge ? rem_sh - {1'b0, den_ff} : rem_sh;
          num_ff <= {num_ff[30:0], rem_ge};
          bit_ff <= bit_ff + 6'h01;
          if (bit_ff == 6'h1F) begin
            rem_ff <= 33'h0_0000_0000;
            bit_ff <= 6'h00;
            idx_ff <= idx_ff + 2'h1;
            if (idx_ff == 2'h3) begin
              // Saturate to the longest displayable time
              if ({num_ff[30:0], rem_ge} > {13'h0000, `OVP_MAX_TICKS})
                inverse_delay_mode_ff <= `OVP_MAX_TICKS;
              else
                inverse_delay_mode_ff <= {num_ff[17:0], rem_ge};
              st_ff <= S_EVAL;
            end else begin
              rq_ff[idx_ff] <= {num_ff[30:0], rem_ge};
              if (idx_ff == 2'h2) begin
                st_ff <= S_EXP;
              end else begin
                num_ff <= {vl_ff[idx_ff + 2'h1], 16'h0000};
                den_ff <= {16'h0000, uset_ff};
              end
            end
          end
        end
        S_EXP: begin
          em1_ff <= em1;
          num_ff <= {2'h0, k_ff, 1'b0, 16'h0000};
          den_ff <= em1;
          st_ff <= S_DIV;
        end
        S_EVAL: begin
          st_ff <= S_IDLE;
          ovr_ff <= ovr_nxt;
          pickup <= pick_nxt;
          blocked <= pick_nxt & blk_smp_ff;
          if (pick_nxt & blk_smp_ff & ~blocked) begin
            evt_block <= 1'b1;
            evt_fault <= ovr_nxt;
            evt_volt <= v_max;
            blkcnt_ff <= blkcnt_ff + 16'h0001;
          end
          if (pick_ok) begin
            start <= 1'b1;
            run_ff <= 1'b1;
            relc_ff <= 19'h0_0000;
            op_ff <= op_nxt;
            trip <= (op_nxt >= exp_t);
            remt_ff <= {1'b0, exp_t} - {1'b0, op_nxt};
          end else begin
            trip <= 1'b0;
            // Operating time held while the release delay runs
            if (run_ff && rel_en && (relc_ff < rel_ff)) begin
              relc_ff <= relc_ff + 19'h0_0001;
              // A START dropped by blocking stays down for the rest of the release
              start <= start & ~blk_smp_ff;
            end else begin
              start <= 1'b0;
              run_ff <= 1'b0;
              op_ff <= 19'h0_0000;
              relc_ff <= 19'h0_0000;
              remt_ff <= {1'b0, exp_t};
            end
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b])
          merge[b*8 +: 8] = dat[b*8 +: 8];
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `OVP_A_EVTV) && (a != 8'h1C);
    end
  endfunction

  assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_ff & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire [31:0] wr_val = merge(ctrl_ff, w_data_ff, w_strb_ff);
  wire [31:0] wr_u = merge({16'h0000, uset_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wr_d = merge({13'h0000, dt_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wr_k = merge({19'h0_0000, k_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wr_e = merge({20'h0_0000, expo_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wr_r = merge({13'h0000, rel_ff}, w_data_ff, w_strb_ff);
  wire [31:0] wr_p = merge(unpri_ff, w_data_ff, w_strb_ff);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `OVP_RST_CTRL;
      uset_ff <= `OVP_RST_USET;
      dt_ff <= `OVP_RST_DT;
      k_ff <= `OVP_RST_K;
      expo_ff <= `OVP_RST_EXPO;
      rel_ff <= `OVP_RST_REL;
      unpri_ff <= `OVP_RST_UNPRI;
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_hold_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OVP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (aw_hold_ff && w_hold_ff && !s_axi_bvalid) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr_ff) ? `OVP_RESP_OKAY : `OVP_RESP_SLVERR;
        case (aw_addr_ff)
          `OVP_A_CTRL: ctrl_ff <= {23'h00_0000, wr_val[8:0]};
          `OVP_A_USET: uset_ff <= wr_u[15:0];
          `OVP_A_DT: dt_ff <= wr_d[18:0];
          `OVP_A_K: k_ff <= wr_k[12:0];
          `OVP_A_EXPO: expo_ff <= wr_e[11:0];
          `OVP_A_REL: rel_ff <= wr_r[18:0];
          `OVP_A_UNPRI: unpri_ff <= wr_p;
          default: ;
        endcase
      end
    end
  end

  wire [47:0] pri_full = (uset_ff * unpri_ff) / `OVP_PRI_DIV;
  wire [31:0] remt_sx = {{12{remt_ff[19]}}, remt_ff};

  reg [31:0] rd_mux;
  always @* begin
    case (s_axi_araddr)
      `OVP_A_CTRL: rd_mux = ctrl_ff;
      `OVP_A_USET: rd_mux = {16'h0000, uset_ff};
      `OVP_A_DT: rd_mux = {13'h0000, dt_ff};
      `OVP_A_K: rd_mux = {19'h0_0000, k_ff};
      `OVP_A_EXPO: rd_mux = {20'h0_0000, expo_ff};
      `OVP_A_REL: rd_mux = {13'h0000, rel_ff};
      `OVP_A_UNPRI: rd_mux = unpri_ff;
      `OVP_A_STAT: rd_mux = {25'h000_0000, ovr_ff, blocked, trip, start, pickup};
      `OVP_A_EXPT: rd_mux = {13'h0000, exp_t};
      `OVP_A_REMT: rd_mux = remt_sx;
      `OVP_A_RATA: rd_mux = {21'h00_0000, ratio[0]};
      `OVP_A_RATB: rd_mux = {21'h00_0000, ratio[1]};
      `OVP_A_RATC: rd_mux = {21'h00_0000, ratio[2]};
      `OVP_A_RATM: rd_mux = {21'h00_0000, rqm_pct[26:16]};
      `OVP_A_PRI: rd_mux = pri_full[31:0];
      `OVP_A_EVT: rd_mux = {blkcnt_ff, 13'h0000, evt_fault};
      `OVP_A_EVTV: rd_mux = {16'h0000, evt_volt};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `OVP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= mapped(s_axi_araddr) ? `OVP_RESP_OKAY : `OVP_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ovp_stage
`default_nettype wire

// [verification/ovp_front_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ovp_front_model (
  input wire logic clk, // Clock
  input wire logic [15:0] tgt_a, // Commanded level A
  input wire logic [15:0] tgt_b, // Commanded level B
  input wire logic [15:0] tgt_c, // Commanded level C
  input wire logic blk_req, // Commanded block
  output var logic [15:0] v_pp_a, // Phase-phase AB
  output var logic [15:0] v_pp_b, // Phase-phase BC
  output var logic [15:0] v_pp_c, // Phase-phase CA
  output var logic [15:0] v_pe_a, // Phase-earth A
  output var logic [15:0] v_pe_b, // Phase-earth B
  output var logic [15:0] v_pe_c, // Phase-earth C
  output var logic [15:0] v_ch3, // Third channel
  output var logic [15:0] v_ch4, // Fourth channel
  output var logic blk_in // Blocking matrix line
);
  initial begin
    {v_pp_a, v_pp_b, v_pp_c, v_pe_a, v_pe_b, v_pe_c, v_ch3, v_ch4} = 128'h0;
    blk_in = 1'b0;
  end
  // Refreshed every clock; the stage picks its own tick
  always @(posedge clk) begin
    v_pp_a <= tgt_a;
    v_pp_b <= tgt_b;
    v_pp_c <= tgt_c;
    // Star values sit below delta, so a wrong select shows
    v_pe_a <= tgt_a >> 1;
    v_pe_b <= tgt_b >> 1;
    v_pe_c <= tgt_c >> 1;
    v_ch3 <= tgt_a;
    v_ch4 <= tgt_b;
    blk_in <= blk_req;
  end
endmodule // ovp_front_model
`default_nettype wire

// [verification/ovp_stage_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ovp_stage_chk #(
  parameter integer CYCLE_CLKS = 625000
)(
  input wire clk, // Clock
  input wire rst, // Async reset
  input wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [1:0] s_axi_bresp, // Write response
  input wire pickup, // Pick-up
  input wire start, // START
  input wire trip, // TRIP
  input wire blocked, // BLOCKED
  input wire evt_block, // Block event
  input wire [2:0] evt_fault // Channels over at event
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic pk_ff;
  logic [31:0] gap_ff;
  logic [31:0] nxt_gap;
  // Clocks since pick-up last moved; evaluation runs once a cycle
  assign nxt_gap = (pickup != pk_ff) ? 32'h0 : gap_ff + 32'h1;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pk_ff <= 1'b0;
      gap_ff <= 32'h0;
    end else begin
      pk_ff <= pickup;
      gap_ff <= nxt_gap;
    end
  end
  chk_block_drop: assert property (blocked |-> !start)
    else $error("start high while blocked");
  chk_start_cause: assert property ($rose(start) |-> pickup && !blocked)
    else $error("start rose without clear pick-up");
  chk_trip_cause: assert property ($rose(trip) |-> start && pickup)
    else $error("trip rose without start");
  chk_evt_rise: assert property ($rose(blocked) |-> evt_block)
    else $error("no event on blocking");
  chk_evt_pulse: assert property (evt_block |=> !evt_block)
    else $error("event pulse too long");
  chk_evt_fault: assert property (evt_block |-> blocked && evt_fault != 3'h0)
    else $error("event without blocked fault");
  chk_eval_gap: assert property ($changed(pickup) |-> gap_ff >= CYCLE_CLKS - 1)
    else $error("pick-up moved between cycles");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule // ovp_stage_chk
bind ovp_stage ovp_stage_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.clk(clk), .rst(rst),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .pickup(pickup),
  .start(start), .trip(trip), .blocked(blocked), .evt_block(evt_block), .evt_fault(evt_fault));
`default_nettype wire

// [verification/ovp_stage_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ovp_defs.vh"
module ovp_stage_bench;
  localparam integer CC = 200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  always #4 clk = ~clk;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, blk = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [15:0] ta = 16'h0, tb = 16'h0, tc = 16'h0;
  wire awready, wready, bvalid, arready, rvalid, pickup, start, trip, blocked, evt_block, blk_in;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] evt_fault;
  wire [15:0] evt_volt, v_pp_a, v_pp_b, v_pp_c, v_pe_a, v_pe_b, v_pe_c, v_ch3, v_ch4;
  integer n_fail = 0, checks = 0, cyc = 0, seed = 32'h5A9263DF, i, j;
  logic [31:0] d, rr [0:2];
  logic [1:0] r;
  logic [7:0] ra [0:6] = '{`OVP_A_CTRL, `OVP_A_USET, `OVP_A_DT, `OVP_A_K, `OVP_A_EXPO, `OVP_A_REL, `OVP_A_PRI};
  logic [31:0] rv [0:6] = '{32'h50, 32'h2904, 32'h8, 32'h5, 32'h64, 32'hC, 32'h3_3450};
  ovp_front_model u_far (.clk(clk), .tgt_a(ta), .tgt_b(tb), .tgt_c(tc), .blk_req(blk), .v_pp_a(v_pp_a),
    .v_pp_b(v_pp_b), .v_pp_c(v_pp_c), .v_pe_a(v_pe_a), .v_pe_b(v_pe_b), .v_pe_c(v_pe_c), .v_ch3(v_ch3),
    .v_ch4(v_ch4), .blk_in(blk_in));
  ovp_stage #(.CYCLE_CLKS(CC)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .v_pp_a(v_pp_a), .v_pp_b(v_pp_b),
    .v_pp_c(v_pp_c), .v_pe_a(v_pe_a), .v_pe_b(v_pe_b), .v_pe_c(v_pe_c), .v_ch3(v_ch3), .v_ch4(v_ch4),
    .blk_in(blk_in), .pickup(pickup), .start(start), .trip(trip), .blocked(blocked),
    .evt_block(evt_block), .evt_fault(evt_fault), .evt_volt(evt_volt));
  task complete_run;
    $display("mismatches %0d compares %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task setv(input [15:0] a, input [15:0] b, input [15:0] c, input logic k);
    @(posedge clk);
    ta <= a;
    tb <= b;
    tc <= c;
    blk <= k;
  endtask
  // Two program cycles guarantee one full evaluation after a change
  task tk(input integer n);
    repeat (n * CC) @(posedge clk);
  endtask
  task wstart(input logic want_blk);
    for (j = 0; j < 3 * CC && (want_blk ? blocked : start) !== 1'b1; j = j + 1)
      @(negedge clk);
  endtask
  function [15:0] hv(input logic on);
    hv = on ? 16'(32'h2905 + {$random(seed)} % 32'hFA0) : 16'h2710;
  endfunction
  function [31:0] mx3(input [31:0] a, input [31:0] b, input [31:0] c);
    mx3 = a > b ? (a > c ? a : c) : (b > c ? b : c);
  endfunction
  // Inverse time in 5 ms ticks for reset dial k (10 ms units) and exponent 1.00
  function [31:0] idt(input [31:0] pct);
    idt = (32'h2 * `OVP_RST_K * 32'h64) / (pct - 32'h64);
  endfunction
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i = i + 1) begin
      rd(ra[i]);
      cmp(d, rv[i]);
    end
    rd(8'h1C);
    cmp(r, `OVP_RESP_SLVERR);
    cmp(d, 32'h0);
    wr(8'h1C, 32'h1);
    cmp(r, `OVP_RESP_SLVERR);
    // One count above threshold, fixed delay of eight cycles
    setv(16'h2905, hv(0), hv(0), 1'b0);
    wstart(1'b0);
    cmp(pickup, 32'h1);
    tk(7);
    @(negedge clk);
    cmp(trip, 32'h0);
    rd(`OVP_A_REMT);
    cmp(d, 32'h1);
    tk(1);
    @(negedge clk);
    cmp(trip, 32'h1);
    rd(`OVP_A_EXPT);
    cmp(d, 32'h8);
    setv(16'h27C9, hv(0), hv(0), 1'b0);
    tk(2);
    @(negedge clk);
    cmp(pickup, 32'h1);
    setv(16'h27C8, hv(0), hv(0), 1'b0);
    tk(2);
    @(negedge clk);
    cmp(pickup, 32'h0);
    cmp(start, 32'h1);
    tk(13);
    @(negedge clk);
    cmp(start, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`OVP_A_CTRL, 32'h10 + i);
      setv(hv(i > 0), hv(i > 1), hv(0), 1'b0);
      tk(2);
      @(negedge clk);
      cmp(pickup, 32'h0);
      setv(hv(1), hv(i > 0), hv(i > 1), 1'b0);
      tk(2);
      @(negedge clk);
      cmp(pickup, 32'h1);
      setv(hv(0), hv(0), hv(0), 1'b0);
      tk(2);
    end
    wr(`OVP_A_CTRL, 32'h10);
    wr(`OVP_A_DT, 32'h0);
    setv(hv(1), hv(0), hv(0), 1'b0);
    wstart(1'b0);
    cmp(trip, 32'h1);
    setv(hv(0), hv(0), hv(0), 1'b0);
    tk(2);
    wr(`OVP_A_DT, 32'h8);
    // Block lands a full cycle before the fault
    setv(hv(0), hv(0), hv(0), 1'b1);
    tk(1);
    setv(16'h2EE0, 16'h2AF8, hv(0), 1'b1);
    wstart(1'b1);
    cmp(evt_block, 32'h1);
    cmp(evt_fault, 32'h3);
    cmp(evt_volt, 32'h2EE0);
    cmp(start, 32'h0);
    rd(`OVP_A_EVT);
    cmp(d[2:0], 32'h3);
    setv(16'h2EE0, 16'h2AF8, hv(0), 1'b0);
    tk(2);
    @(negedge clk);
    cmp(start, 32'h1);
    setv(16'h2EE0, 16'h2AF8, hv(0), 1'b1);
    tk(2);
    @(negedge clk);
    cmp(start, 32'h0);
    cmp(trip, 32'h0);
    setv(hv(0), hv(0), hv(0), 1'b0);
    tk(2);
    wr(`OVP_A_CTRL, 32'h110);
    setv(hv(1), hv(0), hv(0), 1'b0);
    tk(2);
    @(negedge clk);
    cmp(blocked, 32'h0);
    setv(hv(0), hv(0), hv(0), 1'b0);
    tk(2);
    wr(`OVP_A_CTRL, 32'h190);
    setv(hv(1), hv(0), hv(0), 1'b0);
    tk(2);
    @(negedge clk);
    cmp(blocked, 32'h1);
    // Third channel alone, then the star set, which sits below threshold
    wr(`OVP_A_CTRL, 32'h18);
    wr(`OVP_A_USET, 32'h2710);
    setv(16'h3A98, hv(0), hv(0), 1'b0);
    tk(2);
    @(negedge clk);
    cmp(pickup, 32'h1);
    wr(`OVP_A_CTRL, 32'h14);
    tk(2);
    @(negedge clk);
    cmp(pickup, 32'h0);
    for (i = 0; i < 3; i = i + 1)
      rr[i] = 32'h32 + {$random(seed)} % 32'h64;
    // Loaded while star select keeps every channel clear of hysteresis
    setv(16'(rr[0] * 32'h64), 16'(rr[1] * 32'h64), 16'(rr[2] * 32'h64), 1'b0);
    wr(`OVP_A_CTRL, 32'h10);
    tk(2);
    for (i = 0; i < 3; i = i + 1) begin
      rd(8'(`OVP_A_RATA + 8'h4 * i));
      cmp(d, rr[i]);
    end
    rd(`OVP_A_RATM);
    cmp(d, mx3(rr[0], rr[1], rr[2]));
    rd(`OVP_A_PRI);
    cmp(d, 32'h3_0D40);
    @(negedge clk);
    cmp(pickup, {31'h0, mx3(rr[0], rr[1], rr[2]) > 32'h64});
    wr(`OVP_A_CTRL, 32'h20);
    setv(16'h2904, hv(0), hv(0), 1'b0);
    tk(2);
    rd(`OVP_A_EXPT);
    cmp(d, idt(32'h69));
    setv(16'h2AF8, hv(0), hv(0), 1'b0);
    tk(2);
    rd(`OVP_A_EXPT);
    cmp(d, idt(32'h6E));
    complete_run;
  end
endmodule // ovp_stage_bench
`default_nettype wire
